// ---- status_word_defines.vh ----
`ifndef STATUS_WORD_DEFINES_VH
`define STATUS_WORD_DEFINES_VH

// Primary result byte
`define PRIM_OK          8'h01
`define PRIM_FAIL        8'h02

// Secondary serial-port codes
`define SEC_OK           8'h00
`define SEC_LINK_TMO     8'h01
`define SEC_SCRATCH_RO   8'h02
`define SEC_NO_IO        8'h03
`define SEC_OVER_SIZE    8'h04
`define SEC_ODD_LEN      8'h05
`define SEC_NO_REG       8'h06
`define SEC_ZERO_LEN     8'h07
`define SEC_PROTECTED    8'h08
`define SEC_BAD_MEM      8'h09
`define SEC_NO_DIAG      8'h0a
`define SEC_BAD_START    8'h0b
`define SEC_BLK_RETRY    8'h0c
`define SEC_HDR_RETRY    8'h0d
`define SEC_QREQ_RETRY   8'h0e
`define SEC_NOT_SLAVE    8'h0f
`define SEC_BLK_FAULT    8'h14
`define SEC_NO_EOT       8'h15
`define SEC_NO_ACKNAK    8'h16
`define SEC_MENQ_ABORT   8'h17
`define SEC_PENQ_NAKED   8'h18
`define SEC_PENQ_SILENT  8'h19
`define SEC_CTS_TMO      8'h1a
`define SEC_CPU_XFER     8'h1d

// Status word layout
`define SW_PRIM_MSB      7
`define SW_PRIM_LSB      0
`define SW_SEC_MSB       15
`define SW_SEC_LSB       8

// Target classes on req_class
`define CLS_IO           3'h0
`define CLS_REG          3'h1
`define CLS_DIAG         3'h2
`define CLS_SCRATCH      3'h3
`define CLS_OTHER        3'h4

// I/O table starts sit on 1, 9, 17 ...
`define IO_ALIGN_MASK    16'h0007
`define IO_ALIGN_VAL     16'h0001

// Attempt limits; a configured zero selects the default
`define DEF_RETRIES      9'h003
`define DEF_ENQ_TRIES    9'h020
`define LIMIT_ONE        9'h001
`define CFG_NONE         8'h00

// Clear-to-send wait
`define CLK_MHZ          100
`define CTS_TIMEOUT_US   2000
`define CNT_ONE          32'h00000001
`define CNT_ZERO         32'h00000000

`endif

// ---- attempt_limiter.v ----
`timescale 1ns/1ps
`include "status_word_defines.vh"

module attempt_limiter (
   ref_clk,
   resetn,
   clear,
   step,
   limit,
   hit_q
);
   input  wire       ref_clk;
   input  wire       resetn;
   input  wire       clear;
   input  wire       step;
   input  wire [8:0] limit;
   output reg        hit_q;

   reg  [8:0] count_q;
   wire [8:0] count_d;

   assign count_d = count_q + `LIMIT_ONE;

   // Saturates at the limit so a stray step after the abort cannot wrap
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         count_q <= 9'h000;
         hit_q   <= 1'b0;
      end else if (clear) begin
         count_q <= 9'h000;
         hit_q   <= 1'b0;
      end else begin
         hit_q <= 1'b0;
         if (step && count_q < limit) begin
            count_q <= count_d;
            hit_q   <= (count_d == limit);
         end
      end
   end
endmodule // attempt_limiter

// ---- serial_command_status_word.v ----
`timescale 1ns/1ps
`include "status_word_defines.vh"

module serial_command_status_word (
   ref_clk,
   resetn,
   req_start,
   req_internal,
   req_quick_load,
   port_is_slave,
   req_is_write,
   req_class,
   req_len,
   req_addr,
   req_over_size,
   req_absent,
   req_protected,
   req_scratch_ro,
   req_bad_mem,
   req_bad_addr,
   cfg_retries,
   cfg_enq_limit,
   link_done,
   link_timeout,
   blk_fault,
   blk_retry,
   hdr_retry,
   qreq_retry,
   eot_missing,
   acknak_missing,
   menq_fail,
   penq_nak,
   penq_noresp,
   tx_pending,
   cts,
   cpu_xfer_err,
   status_word_q,
   status_wr_q,
   diag1_low_q,
   busy_q,
   link_abort_q
);
   parameter [31:0] CTS_TIMEOUT_CYC = `CTS_TIMEOUT_US * `CLK_MHZ;

   input  wire        ref_clk;
   input  wire        resetn;
   input  wire        req_start;
   input  wire        req_internal;
   input  wire        req_quick_load;
   input  wire        port_is_slave;
   input  wire        req_is_write;
   input  wire [2:0]  req_class;
   input  wire [15:0] req_len;
   input  wire [15:0] req_addr;
   input  wire        req_over_size;
   input  wire        req_absent;
   input  wire        req_protected;
   input  wire        req_scratch_ro;
   input  wire        req_bad_mem;
   input  wire        req_bad_addr;
   input  wire [7:0]  cfg_retries;
   input  wire [7:0]  cfg_enq_limit;
   input  wire        link_done;
   input  wire        link_timeout;
   input  wire        blk_fault;
   input  wire        blk_retry;
   input  wire        hdr_retry;
   input  wire        qreq_retry;
   input  wire        eot_missing;
   input  wire        acknak_missing;
   input  wire        menq_fail;
   input  wire        penq_nak;
   input  wire        penq_noresp;
   input  wire        tx_pending;
   input  wire        cts;
   input  wire        cpu_xfer_err;
   output reg  [15:0] status_word_q;
   output reg         status_wr_q;
   output reg  [7:0]  diag1_low_q;
   output reg         busy_q;
   output reg         link_abort_q;

   localparam [3:0] S_IDLE   = 4'h1;
   localparam [3:0] S_CHECK  = 4'h2;
   localparam [3:0] S_RUN    = 4'h4;
   localparam [3:0] S_REPORT = 4'h8;

   reg  [3:0]  state_q;
   reg  [3:0]  state_d;
   reg  [7:0]  sec_q;
   reg  [7:0]  sec_d;
   reg         silent_seen_q;
   reg  [31:0] cts_cnt_q;
   reg  [31:0] cts_cnt_d;
   reg         run_end;
   reg  [7:0]  run_code;

   wire        clear_cnt;
   wire [8:0]  retry_lim;
   wire [8:0]  enq_lim;
   wire        blk_abort;
   wire        hdr_abort;
   wire        qreq_abort;
   wire        menq_abort;
   wire        penq_abort;
   wire        cts_expired;
   wire [7:0]  check_code;

   // Configured zero means use the default count
   function [8:0] pick_limit;
      input [7:0] cfg;
      input [8:0] def;
      begin
         if (cfg == `CFG_NONE)
            pick_limit = def;
         else
            pick_limit = {1'b0, cfg};
      end
   endfunction

   // Primary byte from the secondary; never zero on any path
   function [7:0] prim_of;
      input [7:0] sec;
      begin
         if (sec == `SEC_OK)
            prim_of = `PRIM_OK;
         else
            prim_of = `PRIM_FAIL;
      end
   endfunction

   // Request screening in one pass; the first match wins
   function [7:0] screen;
      input        quick_load;
      input        slave;
      input        is_wr;
      input [2:0]  cls;
      input [15:0] len;
      input [15:0] addr;
      input        over;
      input        absent;
      input        prot;
      input        ro;
      input        bad_mem;
      input        bad_addr;
      begin
         screen = `SEC_OK;
         if (quick_load && !slave)
            screen = `SEC_NOT_SLAVE;
         else if (quick_load)
            screen = `SEC_OK;
         else if (len == 16'h0000)
            screen = `SEC_ZERO_LEN;
         else if (bad_mem || cls == `CLS_OTHER && bad_addr)
            screen = `SEC_BAD_MEM;
         else if (is_wr && cls == `CLS_SCRATCH && ro)
            screen = `SEC_SCRATCH_RO;
         else if (is_wr && prot)
            screen = `SEC_PROTECTED;
         else if (absent && cls == `CLS_IO)
            screen = `SEC_NO_IO;
         else if (absent && cls == `CLS_REG)
            screen = `SEC_NO_REG;
         else if (absent && cls == `CLS_DIAG)
            screen = `SEC_NO_DIAG;
         else if (len[0] && (cls == `CLS_REG || cls == `CLS_DIAG))
            screen = `SEC_ODD_LEN;
         else if (over)
            screen = `SEC_OVER_SIZE;
         else if (cls == `CLS_SCRATCH && bad_addr)
            screen = `SEC_BAD_START;
         else if (cls == `CLS_IO &&
                  (addr & `IO_ALIGN_MASK) != `IO_ALIGN_VAL)
            screen = `SEC_BAD_START;
      end
   endfunction

   assign retry_lim  = pick_limit(cfg_retries, `DEF_RETRIES) + `LIMIT_ONE;
   assign enq_lim    = pick_limit(cfg_enq_limit, `DEF_ENQ_TRIES);
   assign clear_cnt  = (state_q != S_RUN);
   assign cts_expired = (cts_cnt_q >= CTS_TIMEOUT_CYC);
   assign check_code = screen(req_quick_load, port_is_slave, req_is_write,
                              req_class, req_len, req_addr, req_over_size,
                              req_absent, req_protected, req_scratch_ro,
                              req_bad_mem, req_bad_addr);

   // Retry counters: the abort comes on the failure after the last retry
   attempt_limiter u_blk (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .clear   (clear_cnt),
      .step    (blk_retry),
      .limit   (retry_lim),
      .hit_q   (blk_abort)
   );

   attempt_limiter u_hdr (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .clear   (clear_cnt),
      .step    (hdr_retry),
      .limit   (retry_lim),
      .hit_q   (hdr_abort)
   );

   attempt_limiter u_qreq (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .clear   (clear_cnt),
      .step    (qreq_retry),
      .limit   (retry_lim),
      .hit_q   (qreq_abort)
   );

   // Enquire counters: the abort comes on the last unanswered attempt
   attempt_limiter u_menq (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .clear   (clear_cnt),
      .step    (menq_fail),
      .limit   (enq_lim),
      .hit_q   (menq_abort)
   );

   attempt_limiter u_penq (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .clear   (clear_cnt),
      .step    (penq_nak | penq_noresp),
      .limit   (enq_lim),
      .hit_q   (penq_abort)
   );

   // Link outcome while running; faults outrank a same-cycle done
   always @* begin
      run_end  = 1'b1;
      run_code = `SEC_OK;
      if (cpu_xfer_err)
         run_code = `SEC_CPU_XFER;
      else if (link_timeout)
         run_code = `SEC_LINK_TMO;
      else if (cts_expired)
         run_code = `SEC_CTS_TMO;
      else if (blk_fault)
         run_code = `SEC_BLK_FAULT;
      else if (eot_missing)
         run_code = `SEC_NO_EOT;
      else if (acknak_missing)
         run_code = `SEC_NO_ACKNAK;
      else if (blk_abort)
         run_code = `SEC_BLK_RETRY;
      else if (hdr_abort)
         run_code = `SEC_HDR_RETRY;
      else if (qreq_abort)
         run_code = `SEC_QREQ_RETRY;
      else if (menq_abort)
         run_code = `SEC_MENQ_ABORT;
      else if (penq_abort && silent_seen_q)
         run_code = `SEC_PENQ_SILENT;
      else if (penq_abort)
         run_code = `SEC_PENQ_NAKED;
      else if (link_done)
         run_code = `SEC_OK;
      else
         run_end = 1'b0;
   end

   // Clear-to-send wait only counts while a transmit is held off
   always @* begin
      cts_cnt_d = `CNT_ZERO;
      if (state_q == S_RUN && tx_pending && !cts && !cts_expired)
         cts_cnt_d = cts_cnt_q + `CNT_ONE;
      else if (state_q == S_RUN && tx_pending && !cts)
         cts_cnt_d = cts_cnt_q;
   end

   always @* begin
      state_d = state_q;
      sec_d   = sec_q;
      case (state_q)
         S_IDLE: begin
            // A start while busy is not taken; pacing is the requester's
            if (req_start) begin
               state_d = S_CHECK;
               sec_d   = `SEC_OK;
            end
         end
         S_CHECK: begin
            sec_d = check_code;
            if (check_code != `SEC_OK || req_internal || req_quick_load)
               state_d = S_REPORT;
            else
               state_d = S_RUN;
         end
         S_RUN: begin
            if (run_end) begin
               sec_d   = run_code;
               state_d = S_REPORT;
            end
         end
         S_REPORT: begin
            state_d = S_IDLE;
         end
         default: begin
            state_d = S_IDLE;
            sec_d   = `SEC_OK;
         end
      endcase
   end

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_q       <= S_IDLE;
         sec_q         <= `SEC_OK;
         silent_seen_q <= 1'b0;
         cts_cnt_q     <= `CNT_ZERO;
      end else begin
         state_q   <= state_d;
         sec_q     <= sec_d;
         cts_cnt_q <= cts_cnt_d;
         // Any silent enquire turns the final code from 18 into 19
         if (state_q != S_RUN)
            silent_seen_q <= 1'b0;
         else if (penq_noresp)
            silent_seen_q <= 1'b1;
      end
   end

   // Word and mirror leave together so a poller never sees half a result
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         status_word_q <= 16'h0000;
         status_wr_q   <= 1'b0;
         diag1_low_q   <= `SEC_OK;
         busy_q        <= 1'b0;
         link_abort_q  <= 1'b0;
      end else begin
         status_wr_q  <= 1'b0;
         link_abort_q <= 1'b0;
         busy_q       <= (state_d != S_IDLE);
         if (state_q == S_RUN && run_end && run_code != `SEC_OK)
            link_abort_q <= 1'b1;
         if (state_q == S_REPORT) begin
            status_word_q <= {sec_q, prim_of(sec_q)};
            diag1_low_q   <= sec_q;
            status_wr_q   <= 1'b1;
         end
      end
   end
endmodule // serial_command_status_word

// ---- status_word_checker_assertions.sv ----
`timescale 1ns/1ps
module status_word_checker (
   input wire        ref_clk,
   input wire        resetn,
   input wire        req_start,
   input wire        req_quick_load,
   input wire        port_is_slave,
   input wire [15:0] req_len,
   input wire        link_done,
   input wire        link_timeout,
   input wire        cpu_xfer_err,
   input wire [15:0] status_word_q,
   input wire        status_wr_q,
   input wire [7:0]  diag1_low_q,
   input wire        busy_q,
   input wire        link_abort_q
);
   reg  [1:0] busy_cnt_q;
   reg        ended_q;
   // Also true in a report cycle; properties guard on the write timing
   wire       in_run = busy_q && busy_cnt_q != 2'h0 && !ended_q;
   wire       qbad   = req_quick_load && !port_is_slave;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Skips the check cycle and anything after the first link event
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         busy_cnt_q <= 2'd0;
         ended_q    <= 1'b0;
      end else begin
         if (!busy_q) busy_cnt_q <= 2'd0;
         else if (busy_cnt_q != 2'd3) busy_cnt_q <= busy_cnt_q + 2'd1;
         ended_q <= busy_q && (ended_q || (in_run &&
                    (link_done || link_timeout || cpu_xfer_err)));
      end
   end
   a_never_zero: assert property (status_wr_q |->
      status_word_q != 16'h0000)
      else $error("status word written as zero");
   a_clean_primary: assert property (status_wr_q &&
      status_word_q[15:8] == 8'h00 |-> status_word_q[7:0] == 8'h01)
      else $error("clean result without primary one");
   a_error_primary: assert property (status_wr_q &&
      status_word_q[15:8] != 8'h00 |-> status_word_q[7:0] > 8'h01)
      else $error("error result with low primary");
   a_diag_mirror: assert property (status_wr_q |->
      diag1_low_q == status_word_q[15:8])
      else $error("diag copy differs from secondary");
   a_word_single: assert property (!status_wr_q |->
      $stable(status_word_q) && $stable(diag1_low_q))
      else $error("status changed without write");
   a_zero_len: assert property (req_start && !busy_q ##1
      (req_len == 16'h0000 && !req_quick_load) |-> ##2
      (status_wr_q && status_word_q == 16'h0702))
      else $error("zero length not reported");
   a_quick_slave: assert property (req_start && !busy_q ##1 qbad
      |-> ##2 (status_wr_q && status_word_q == 16'h0f02))
      else $error("quick load on non-slave not reported");
   a_link_tmo: assert property (in_run && link_timeout &&
      !cpu_xfer_err ##1 !status_wr_q |-> ##1
      (status_wr_q && status_word_q == 16'h0102))
      else $error("link timeout not reported");
   a_cpu_xfer: assert property (in_run && cpu_xfer_err ##1
      !status_wr_q |-> ##1 (status_wr_q && status_word_q == 16'h1d02))
      else $error("controller transfer error not reported");
   a_busy_done: assert property (status_wr_q |-> !busy_q)
      else $error("busy still set at status write");
   a_abort_pair: assert property (link_abort_q |-> ##1
      (status_wr_q && status_word_q[15:8] != 8'h00))
      else $error("link abort without error status");
   cover property (status_wr_q && status_word_q == 16'h0001);
   cover property (status_wr_q && status_word_q[15:8] == 8'h1a);
   cover property (in_run && link_timeout);
   cover property (link_abort_q);
endmodule // status_word_checker
bind serial_command_status_word status_word_checker u_chk (.*);

// ---- ladder_poller.sv ----
`timescale 1ns/1ps
module ladder_poller (
   input  wire        ref_clk,
   input  wire        resetn,
   input  wire        req_start,
   input  wire        status_wr_q,
   input  wire [15:0] status_word_q,
   output reg  [15:0] poll_word_q
);
   // Zeroed at issue, so any non-zero value marks completion
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) poll_word_q <= 16'h0000;
      else if (status_wr_q) poll_word_q <= status_word_q;
      else if (req_start) poll_word_q <= 16'h0000;
   end
endmodule // ladder_poller

// ---- serial_command_status_word_tb.sv ----
`timescale 1ns/1ps
`include "status_word_defines.vh"
module serial_command_status_word_tb;
   reg         ref_clk;
   reg         resetn;
   reg         req_start;
   reg         req_internal;
   reg         req_quick_load;
   reg         port_is_slave;
   reg         req_is_write;
   reg  [2:0]  req_class;
   reg  [15:0] req_len;
   reg  [15:0] req_addr;
   reg  [5:0]  flags;
   reg  [7:0]  cfg_retries;
   reg  [7:0]  cfg_enq_limit;
   reg  [11:0] ev;
   reg         tx_pending;
   reg         cts;
   reg  [31:0] r;
   reg  [15:0] e;
   reg  [15:0] exp_q[$];
   wire [15:0] status_word_q;
   wire        status_wr_q;
   wire [7:0]  diag1_low_q;
   wire        busy_q;
   wire [15:0] poll_word_q;
   integer     miscompares;
   integer     samples_checked;
   integer     i;
   // Short clear-to-send limit keeps the run brief
   serial_command_status_word #(.CTS_TIMEOUT_CYC(32'd20)) dut (
      .req_over_size(flags[5]), .req_absent(flags[4]),
      .req_protected(flags[3]), .req_scratch_ro(flags[2]),
      .req_bad_mem(flags[1]), .req_bad_addr(flags[0]),
      .link_done(ev[0]), .link_timeout(ev[1]), .blk_fault(ev[2]),
      .blk_retry(ev[3]), .hdr_retry(ev[4]), .qreq_retry(ev[5]),
      .eot_missing(ev[6]), .acknak_missing(ev[7]), .menq_fail(ev[8]),
      .penq_nak(ev[9]), .penq_noresp(ev[10]), .cpu_xfer_err(ev[11]),
      .link_abort_q(), .*);
   ladder_poller partner (.*);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task check(input [15:0] seen, input [15:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task complete_run;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      if (status_wr_q === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
         check(status_word_q, e);
         check({8'h00, diag1_low_q}, {8'h00, e[15:8]});
      end
   end
   task start(input [7:0] c);
      exp_q.push_back(c == `SEC_OK ? 16'h0001 : {c, `PRIM_FAIL});
      r = lfsr(r);
      cts = r[0];
      req_start = 1'b1;
      @(negedge ref_clk);
      req_start = 1'b0;
   endtask
   // One request outstanding: wait for the polled word to turn non-zero
   task finish;
      for (i = 0; i < 300 && poll_word_q === 16'h0000; i = i + 1)
         @(negedge ref_clk);
      if (poll_word_q === 16'h0000) begin
         miscompares = miscompares + 1;
         complete_run;
      end else begin
         tx_pending = 1'b0;
      end
   endtask
   task scr(input [1:0] qw, input [2:0] cls, input [1:0] l,
            input [3:0] a, input [5:0] f, input [7:0] c);
      r = lfsr(r);
      req_internal = 1'b1;
      req_quick_load = qw[1];
      port_is_slave = qw[1] ? 1'b0 : r[3];
      req_is_write = qw[0];
      req_class = cls;
      req_len = {14'h0000, l};
      req_addr = (cls == `CLS_IO) ? {12'h000, a} : r[19:4];
      flags = f;
      start(c);
      finish;
   endtask
   task run(input [3:0] id, input [5:0] n, input [7:0] c);
      r = lfsr(r);
      req_internal = 1'b0;
      req_quick_load = 1'b0;
      req_is_write = r[5];
      req_class = `CLS_REG;
      req_len = {r[14:8], 1'b0} + 16'h0002;
      flags = 6'h00;
      start(c);
      @(negedge ref_clk);
      if (id == 4'd12) begin
         tx_pending = 1'b1;
         cts = 1'b0;
      end
      for (i = 0; i < n; i = i + 1) begin
         ev = 12'h001 << id;
         @(negedge ref_clk);
         ev = 12'h000;
         @(negedge ref_clk);
      end
      if (c == `SEC_OK) begin
         ev = 12'h001;
         @(negedge ref_clk);
         ev = 12'h000;
      end
      finish;
   endtask
   initial begin
      resetn = 1'b0;
      req_start = 1'b0;
      req_internal = 1'b0;
      req_quick_load = 1'b0;
      port_is_slave = 1'b0;
      req_is_write = 1'b0;
      req_class = 3'h0;
      req_len = 16'h0000;
      req_addr = 16'h0000;
      flags = 6'h00;
      cfg_retries = 8'h00;
      cfg_enq_limit = 8'h00;
      ev = 12'h000;
      tx_pending = 1'b0;
      cts = 1'b1;
      r = 32'h82a9;
      miscompares = 0;
      samples_checked = 0;
      repeat (3) @(negedge ref_clk);
      resetn = 1'b1;
      @(negedge ref_clk);
      scr(2'b10, `CLS_REG, 2'h2, 4'h0, 6'h00, `SEC_NOT_SLAVE);
      scr(2'b00, `CLS_REG, 2'h0, 4'h0, 6'h00, `SEC_ZERO_LEN);
      scr(2'b01, `CLS_SCRATCH, 2'h0, 4'h0, 6'h04, `SEC_ZERO_LEN);
      scr(2'b00, `CLS_SCRATCH, 2'h2, 4'h0, 6'h02, `SEC_BAD_MEM);
      scr(2'b00, `CLS_OTHER, 2'h2, 4'h0, 6'h01, `SEC_BAD_MEM);
      scr(2'b01, `CLS_SCRATCH, 2'h2, 4'h0, 6'h04, `SEC_SCRATCH_RO);
      scr(2'b01, `CLS_REG, 2'h2, 4'h0, 6'h08, `SEC_PROTECTED);
      scr(2'b00, `CLS_IO, 2'h2, 4'h9, 6'h10, `SEC_NO_IO);
      scr(2'b00, `CLS_REG, 2'h2, 4'h0, 6'h10, `SEC_NO_REG);
      scr(2'b00, `CLS_DIAG, 2'h2, 4'h0, 6'h10, `SEC_NO_DIAG);
      scr(2'b00, `CLS_REG, 2'h3, 4'h0, 6'h00, `SEC_ODD_LEN);
      scr(2'b00, `CLS_DIAG, 2'h1, 4'h0, 6'h00, `SEC_ODD_LEN);
      scr(2'b00, `CLS_REG, 2'h2, 4'h0, 6'h20, `SEC_OVER_SIZE);
      scr(2'b00, `CLS_SCRATCH, 2'h2, 4'h0, 6'h01, `SEC_BAD_START);
      scr(2'b00, `CLS_IO, 2'h2, 4'h8, 6'h00, `SEC_BAD_START);
      scr(2'b00, `CLS_IO, 2'h2, 4'h9, 6'h00, `SEC_OK);
      run(4'd0, 6'd0, `SEC_OK);
      run(4'd11, 6'd1, `SEC_CPU_XFER);
      run(4'd1, 6'd1, `SEC_LINK_TMO);
      run(4'd12, 6'd0, `SEC_CTS_TMO);
      run(4'd2, 6'd1, `SEC_BLK_FAULT);
      run(4'd6, 6'd1, `SEC_NO_EOT);
      run(4'd7, 6'd1, `SEC_NO_ACKNAK);
      run(4'd3, 6'd3, `SEC_OK);
      run(4'd3, 6'd4, `SEC_BLK_RETRY);
      run(4'd4, 6'd4, `SEC_HDR_RETRY);
      run(4'd5, 6'd4, `SEC_QREQ_RETRY);
      run(4'd8, 6'd31, `SEC_OK);
      run(4'd8, 6'd32, `SEC_MENQ_ABORT);
      run(4'd9, 6'd32, `SEC_PENQ_NAKED);
      run(4'd10, 6'd32, `SEC_PENQ_SILENT);
      cfg_retries = 8'h01;
      cfg_enq_limit = 8'h05;
      run(4'd3, 6'd2, `SEC_BLK_RETRY);
      run(4'd9, 6'd5, `SEC_PENQ_NAKED);
      complete_run;
   end
endmodule // serial_command_status_word_tb
